/* logic/sice_engine.sv */
// serial isp command engine: link shifter and memory sequencer
`timescale 1ns/10ps
module sice_engine
   import sice_pkg::*;
#(
   parameter int unsigned FLASH_WAIT_CYC  = SICE_FLASH_CYC,
   parameter int unsigned EEPROM_WAIT_CYC = SICE_EEPROM_CYC,
   parameter int unsigned ERASE_WAIT_CYC  = SICE_ERASE_CYC,
   parameter int unsigned FUSE_WAIT_CYC   = SICE_FUSE_CYC
) (
   // core clock and reset
   input  wire logic       clock_i,
   input  wire logic       rst_i,
   // programming link pins
   input  wire logic       reset_pin_i,
   input  wire logic       sck_i,
   input  wire logic       mosi_i,
   output logic            miso_o,
   // status
   output logic            prog_mode_o,
   output logic            operation_pending_flag_o,
   output logic [7:0]      ext_addr_o
);

   // link state on the rising sck edge
   typedef struct packed {
      logic [31:0] sh;
      logic [4:0]  cnt;
      logic [23:0] hdr;
      logic [31:0] word;
      logic        ht;
      logic        wt;
   } sice_rise_t;

   // core state
   typedef struct packed {
      logic        pin_s1;
      logic        pin_s2;
      logic        ht_s1;
      logic        ht_s2;
      logic        ht_p;
      logic        wt_s1;
      logic        wt_s2;
      logic        wt_p;
      sice_state_t st;
      logic        en;
      logic [20:0] cnt;
      logic [12:0] idx;
      logic [6:0]  fpage;
      logic [7:0]  rd;
      logic [7:0]  fuse_lo;
      logic [7:0]  fuse_hi;
      logic [7:0]  fuse_ext;
      logic [7:0]  lock;
      logic [7:0]  ext;
      logic [31:0] epg;
      logic [3:0]  emask;
      logic        pend;
   } sice_core_t;

   sice_rise_t  r_q, r_d;
   logic [7:0]  tx_q, tx_d;
   sice_core_t  c_q, c_d;

   // memories
   logic [15:0] flash_mem [SICE_FL_WORDS];
   logic [7:0]  ee_mem    [SICE_EE_BYTES];
   logic [15:0] fbuf_mem  [64];

   // memory write requests from the sequencer
   logic        fl_we, ee_we, fb_we;
   logic [12:0] fl_addr;
   logic [15:0] fl_dat;
   logic [8:0]  ee_addr;
   logic [7:0]  ee_dat;
   logic [5:0]  fb_idx;
   logic [15:0] fb_dat;

   // incoming word split into bytes
   logic [7:0]  b1, b2, b3, b4;
   logic [7:0]  h1, h2, h3;
   logic [12:0] hadr;
   logic        busy;

   assign b1 = r_q.word[31:24];
   assign b2 = r_q.word[23:16];
   assign b3 = r_q.word[15:8];
   assign b4 = r_q.word[7:0];
   assign h1 = r_q.hdr[23:16];
   assign h2 = r_q.hdr[15:8];
   assign h3 = r_q.hdr[7:0];
   assign hadr = {h2[4:0], h3};
   assign busy = (c_q.st != SICE_IDLE);

   // link shifter: bit count, header after 24 bits, word after 32
   always_comb begin
      r_d = r_q;
      r_d.sh = {r_q.sh[30:0], mosi_i};
      r_d.cnt = r_q.cnt + 5'h01;
      if (r_q.cnt == 5'h17) begin
         r_d.hdr = r_d.sh[23:0];
         r_d.ht = ~r_q.ht;
      end
      if (r_q.cnt == 5'h1F) begin
         r_d.word = r_d.sh;
         r_d.wt = ~r_q.wt;
      end
   end

   // pin high aborts any partial frame, so a reset pulse resyncs the link
   always_ff @(posedge sck_i or posedge reset_pin_i) begin
      if (reset_pin_i) begin
         r_q <= '0;
      end else begin
         r_q <= r_d;
      end
   end

   // miso: at each byte boundary load the last byte received, or the
   // read result before byte four; the core holds rd stable by then
   always_comb begin
      tx_d = {tx_q[6:0], 1'b0};
      if (r_q.cnt[2:0] == 3'h0 && r_q.cnt != 5'h00) begin
         tx_d = (r_q.cnt == 5'h18) ? c_q.rd : r_q.sh[7:0];
      end else if (r_q.cnt == 5'h00) begin
         tx_d = r_q.sh[7:0];
      end
   end

   always_ff @(negedge sck_i or posedge reset_pin_i) begin
      if (reset_pin_i) begin
         tx_q <= 8'h00;
      end else begin
         tx_q <= tx_d;
      end
   end

   assign miso_o = tx_q[7];

   // core sequencer: decode, busy timing, memory stepping
   always_comb begin
      c_d = c_q;
      fl_we = 1'b0;
      ee_we = 1'b0;
      fb_we = 1'b0;
      fl_addr = '0;
      fl_dat = '0;
      ee_addr = '0;
      ee_dat = '0;
      fb_idx = '0;
      fb_dat = '0;
      c_d.pin_s1 = reset_pin_i;
      c_d.pin_s2 = c_q.pin_s1;
      c_d.ht_s1 = r_q.ht;
      c_d.ht_s2 = c_q.ht_s1;
      c_d.ht_p = c_q.ht_s2;
      c_d.wt_s1 = r_q.wt;
      c_d.wt_s2 = c_q.wt_s1;
      c_d.wt_p = c_q.wt_s2;
      if (c_q.cnt != 21'h0) begin
         c_d.cnt = c_q.cnt - 21'h1;
      end
      // read data prepared once the first three bytes are in
      if (c_q.ht_s2 != c_q.ht_p && !c_q.pin_s2) begin
         case (h1)
            SICE_OP_POLL: c_d.rd = {7'h00, busy};
            SICE_OP_RDLO: c_d.rd = flash_mem[hadr][7:0];
            SICE_OP_RDHI: c_d.rd = flash_mem[hadr][15:8];
            SICE_OP_EERD: c_d.rd = ee_mem[{h2[0], h3}];
            SICE_OP_FRD0: c_d.rd = (h2 == SICE_SUB_HI) ?
                                   c_q.fuse_ext : c_q.fuse_lo;
            SICE_OP_FRD1: c_d.rd = (h2 == SICE_SUB_HI) ?
                                   c_q.fuse_hi : c_q.lock;
            default:      c_d.rd = 8'h00;
         endcase
      end
      // sequencer stepping
      case (c_q.st)
         SICE_FCOPY: begin
            fl_we = 1'b1;
            fl_addr = {c_q.fpage, c_q.idx[5:0]};
            fl_dat = fbuf_mem[c_q.idx[5:0]];
            c_d.idx = c_q.idx + 13'h1;
            if (c_q.idx[5:0] == SICE_PG_LAST) begin
               c_d.st = SICE_WAIT;
            end
         end
         SICE_ERASE: begin
            fl_we = 1'b1;
            fl_addr = c_q.idx;
            fl_dat = {SICE_ERASED, SICE_ERASED};
            ee_we = 1'b1;
            ee_addr = c_q.idx[8:0];
            ee_dat = SICE_ERASED;
            c_d.idx = c_q.idx + 13'h1;
            if (c_q.idx == SICE_FL_LAST) begin
               c_d.st = SICE_WAIT;
            end
         end
         SICE_WAIT: begin
            if (c_q.cnt == 21'h0) begin
               c_d.st = SICE_IDLE;
            end
         end
         default: begin
            // eeprom page commit steps through four masked slots
            if (c_q.emask != 4'h0 && c_q.idx[12]) begin
               ee_we = c_q.emask[c_q.idx[1:0]];
               ee_addr = {c_q.fpage, c_q.idx[1:0]};
               ee_dat = c_q.epg[c_q.idx[1:0]*8 +: 8];
               c_d.idx = c_q.idx + 13'h1;
               if (c_q.idx[1:0] == 2'h3) begin
                  c_d.emask = 4'h0;
                  c_d.idx = '0; // a later load must not restart the commit
                  c_d.st = SICE_WAIT;
               end
            end
         end
      endcase
      // full instruction decode
      if (c_q.wt_s2 != c_q.wt_p && !c_q.pin_s2) begin
         if (b1 == SICE_OP_AC && b2 == SICE_SUB_EN) begin
            c_d.en = 1'b1;
         end else if (b1 == SICE_OP_EXT) begin
            c_d.ext = b3;
         end else if (c_q.en && !busy) begin
            case (b1)
               SICE_OP_AC: begin
                  c_d.cnt = 21'(FUSE_WAIT_CYC);
                  c_d.st = SICE_WAIT;
                  case (b2)
                     SICE_SUB_ERASE: begin
                        c_d.st = SICE_ERASE;
                        c_d.idx = '0;
                        c_d.cnt = 21'(ERASE_WAIT_CYC);
                        c_d.lock = SICE_FUSE_RST;
                     end
                     SICE_SUB_LOCK: c_d.lock = c_q.lock & b4;
                     SICE_SUB_FLO:  c_d.fuse_lo = b4;
                     SICE_SUB_FHI:  c_d.fuse_hi = b4;
                     SICE_SUB_FEXT: c_d.fuse_ext = b4;
                     default:       c_d.st = SICE_IDLE;
                  endcase
               end
               SICE_OP_LDLO: begin
                  fb_we = 1'b1;
                  fb_idx = b3[5:0];
                  fb_dat = {SICE_ERASED, b4};
               end
               SICE_OP_LDHI: begin
                  fb_we = 1'b1;
                  fb_idx = b3[5:0];
                  fb_dat = {b4, fbuf_mem[b3[5:0]][7:0]};
               end
               SICE_OP_WRPG: begin
                  c_d.st = SICE_FCOPY;
                  c_d.fpage = {b2[4:0], b3[7:6]};
                  c_d.idx = '0;
                  c_d.cnt = 21'(FLASH_WAIT_CYC);
               end
               SICE_OP_EEWR: begin
                  ee_we = 1'b1;
                  ee_addr = {b2[0], b3};
                  ee_dat = b4;
                  c_d.st = SICE_WAIT;
                  c_d.cnt = 21'(EEPROM_WAIT_CYC);
               end
               SICE_OP_EELD: begin
                  c_d.epg[b3[1:0]*8 +: 8] = b4;
                  c_d.emask[b3[1:0]] = 1'b1;
               end
               SICE_OP_EEPG: begin
                  c_d.fpage = {b2[0], b3[7:2]};
                  c_d.idx = 13'h1000;
                  c_d.cnt = 21'(EEPROM_WAIT_CYC);
               end
               default: begin
                  c_d.cnt = c_q.cnt;
               end
            endcase
         end
      end
      // pin high leaves programming mode
      if (c_q.pin_s2) begin
         c_d.en = 1'b0;
      end
      // busy flag registered so the pin comes straight from a flop
      c_d.pend = (c_d.st != SICE_IDLE);
   end

   always_ff @(posedge clock_i) begin
      if (rst_i) begin
         c_q <= '0;
         c_q.st <= SICE_IDLE;
         c_q.pin_s1 <= 1'b1;
         c_q.pin_s2 <= 1'b1;
         c_q.fuse_lo <= SICE_FUSE_RST;
         c_q.fuse_hi <= SICE_FUSE_RST;
         c_q.fuse_ext <= SICE_FUSE_RST;
         c_q.lock <= SICE_FUSE_RST;
      end else begin
         c_q <= c_d;
      end
   end

   // memory arrays
   always_ff @(posedge clock_i) begin
      if (fl_we) begin
         flash_mem[fl_addr] <= fl_dat;
      end
      if (ee_we) begin
         ee_mem[ee_addr] <= ee_dat;
      end
      if (fb_we) begin
         fbuf_mem[fb_idx] <= fb_dat;
      end
   end

   // status outputs straight from flip-flops
   assign prog_mode_o = c_q.en;
   assign operation_pending_flag_o = c_q.pend;
   assign ext_addr_o = c_q.ext;

endmodule

/* logic/sice_pkg.sv */
// shared constants and types of the serial isp command engine
package sice_pkg;
   // opcodes in the first byte
   localparam logic [7:0] SICE_OP_AC     = 8'hAC;
   localparam logic [7:0] SICE_OP_POLL   = 8'hF0;
   localparam logic [7:0] SICE_OP_EXT    = 8'h4D;
   localparam logic [7:0] SICE_OP_LDHI   = 8'h48;
   localparam logic [7:0] SICE_OP_LDLO   = 8'h40;
   localparam logic [7:0] SICE_OP_EELD   = 8'hC1;
   localparam logic [7:0] SICE_OP_RDHI   = 8'h28;
   localparam logic [7:0] SICE_OP_RDLO   = 8'h20;
   localparam logic [7:0] SICE_OP_EERD   = 8'hA0;
   localparam logic [7:0] SICE_OP_FRD0   = 8'h50;
   localparam logic [7:0] SICE_OP_FRD1   = 8'h58;
   localparam logic [7:0] SICE_OP_WRPG   = 8'h4C;
   localparam logic [7:0] SICE_OP_EEWR   = 8'hC0;
   localparam logic [7:0] SICE_OP_EEPG   = 8'hC2;
   // second byte selectors
   localparam logic [7:0] SICE_SUB_EN    = 8'h53;
   localparam logic [7:0] SICE_SUB_ERASE = 8'h80;
   localparam logic [7:0] SICE_SUB_LOCK  = 8'hE0;
   localparam logic [7:0] SICE_SUB_FLO   = 8'hA0;
   localparam logic [7:0] SICE_SUB_FHI   = 8'hA8;
   localparam logic [7:0] SICE_SUB_FEXT  = 8'hA4;
   localparam logic [7:0] SICE_SUB_HI    = 8'h08;
   // sizes and erased values
   localparam int unsigned SICE_FL_WORDS = 8192;
   localparam int unsigned SICE_EE_BYTES = 512;
   localparam logic [7:0]  SICE_ERASED   = 8'hFF;
   localparam logic [7:0]  SICE_FUSE_RST = 8'hFF;
   localparam logic [12:0] SICE_FL_LAST  = 13'h1FFF;
   localparam logic [5:0]  SICE_PG_LAST  = 6'h3F;
   // wait times in ns and clock period in ns
   localparam int unsigned SICE_CLK_NS      = 8;
   localparam int unsigned SICE_FLASH_NS    = 2600000;
   localparam int unsigned SICE_EEPROM_NS   = 3600000;
   localparam int unsigned SICE_ERASE_NS    = 10500000;
   localparam int unsigned SICE_FUSE_NS     = 4500000;
   // busy lengths in cycles, rounded up
   localparam int unsigned SICE_FLASH_CYC  =
      (SICE_FLASH_NS + SICE_CLK_NS - 1) / SICE_CLK_NS;
   localparam int unsigned SICE_EEPROM_CYC =
      (SICE_EEPROM_NS + SICE_CLK_NS - 1) / SICE_CLK_NS;
   localparam int unsigned SICE_ERASE_CYC  =
      (SICE_ERASE_NS + SICE_CLK_NS - 1) / SICE_CLK_NS;
   localparam int unsigned SICE_FUSE_CYC   =
      (SICE_FUSE_NS + SICE_CLK_NS - 1) / SICE_CLK_NS;
   // sequencer states
   typedef enum logic [1:0] {
      SICE_IDLE  = 2'b00,
      SICE_FCOPY = 2'b01,
      SICE_ERASE = 2'b10,
      SICE_WAIT  = 2'b11
   } sice_state_t;
endpackage

/* tb/sice_engine_monitor.sv */
// port checker of the isp command engine
`timescale 1ns/10ps
module sice_engine_monitor #(
   parameter int unsigned FLASH_WAIT_CYC  = 100,
   parameter int unsigned EEPROM_WAIT_CYC = 100,
   parameter int unsigned ERASE_WAIT_CYC  = 100,
   parameter int unsigned FUSE_WAIT_CYC   = 100
) (
   // core side
   input wire logic       clock_i,
   input wire logic       rst_i,
   // link pins
   input wire logic       reset_pin_i,
   input wire logic       sck_i,
   input wire logic       mosi_i,
   input wire logic       miso_o,
   // status
   input wire logic       prog_mode_o,
   input wire logic       operation_pending_flag_o,
   input wire logic [7:0] ext_addr_o
);
   localparam int PEND_MAX = 16384 + FLASH_WAIT_CYC + EEPROM_WAIT_CYC
      + ERASE_WAIT_CYC + FUSE_WAIT_CYC;
   logic [4:0]  bit_cnt_q;
   logic [31:0] sh_q;
   int          pend_cnt_q;
   // shadow of the link shifter, cleared by the reset pin
   always_ff @(posedge sck_i or posedge reset_pin_i) begin
      if (reset_pin_i) begin
         bit_cnt_q <= 5'h00;
         sh_q      <= 32'h0;
      end else begin
         bit_cnt_q <= bit_cnt_q + 5'h01;
         sh_q      <= {sh_q[30:0], mosi_i};
      end
   end
   // length of the current busy stretch
   always_ff @(posedge clock_i) begin
      if (rst_i || !operation_pending_flag_o)
         pend_cnt_q <= 0;
      else
         pend_cnt_q <= pend_cnt_q + 1;
   end
   chk_echo_byte: assert property (
      @(posedge sck_i) disable iff (reset_pin_i)
      bit_cnt_q inside {[5'h08:5'h17]} |-> miso_o == sh_q[7])
      else $error("miso does not echo the previous byte");
   chk_miso_fall: assert property (
      @(posedge clock_i) disable iff (rst_i || reset_pin_i)
      sck_i && $past(sck_i) |-> $stable(miso_o))
      else $error("miso moved while sck high");
   chk_mode_drop: assert property (
      @(posedge clock_i) disable iff (rst_i)
      reset_pin_i [*4] |=> !prog_mode_o)
      else $error("mode kept with reset pin high");
   chk_miso_quiet: assert property (
      @(posedge clock_i) disable iff (rst_i)
      reset_pin_i && $past(reset_pin_i) |-> miso_o == 1'b0)
      else $error("miso driven while reset pin high");
   chk_mode_frame: assert property (
      @(posedge clock_i) disable iff (rst_i)
      $rose(prog_mode_o) |-> bit_cnt_q == 5'h00 && !reset_pin_i)
      else $error("mode entered mid instruction");
   chk_pend_gate: assert property (
      @(posedge clock_i) disable iff (rst_i)
      $rose(operation_pending_flag_o) |-> prog_mode_o && bit_cnt_q == 5'h00)
      else $error("busy started outside a complete instruction");
   chk_pend_min: assert property (
      @(posedge clock_i) disable iff (rst_i)
      $rose(operation_pending_flag_o) |=> operation_pending_flag_o [*8])
      else $error("busy flag too short");
   chk_pend_max: assert property (
      @(posedge clock_i) disable iff (rst_i) pend_cnt_q <= PEND_MAX)
      else $error("busy flag never clears");
   chk_ext_frame: assert property (
      @(posedge clock_i) disable iff (rst_i)
      !$stable(ext_addr_o) |-> bit_cnt_q == 5'h00)
      else $error("extended address changed mid instruction");
   // main scenarios seen
   cov_mode: cover property (@(posedge clock_i) $rose(prog_mode_o));
   cov_busy: cover property (@(posedge clock_i)
      $fell(operation_pending_flag_o));
   cov_ext: cover property (@(posedge clock_i) $changed(ext_addr_o));
endmodule

bind sice_engine sice_engine_monitor #(
   .FLASH_WAIT_CYC (FLASH_WAIT_CYC),
   .EEPROM_WAIT_CYC(EEPROM_WAIT_CYC),
   .ERASE_WAIT_CYC (ERASE_WAIT_CYC),
   .FUSE_WAIT_CYC  (FUSE_WAIT_CYC)
) mon_u (
   .clock_i(clock_i), .rst_i(rst_i), .reset_pin_i(reset_pin_i),
   .sck_i(sck_i), .mosi_i(mosi_i), .miso_o(miso_o),
   .prog_mode_o(prog_mode_o), .ext_addr_o(ext_addr_o),
   .operation_pending_flag_o(operation_pending_flag_o)
);

/* tb/sice_prog_model.sv */
// behavioural serial programmer on the link
`timescale 1ns/10ps
module sice_prog_model (
   // link toward the engine
   output logic      sck_o,
   output logic      mosi_o,
   input  wire logic miso_i
);
   // clock parked low from power-up
   initial begin
      sck_o  = 1'b0;
      mosi_o = 1'b0;
   end
   // whole four-byte frame, msb first
   task automatic xfer(input logic [31:0] ins, input int half,
                       output logic [31:0] rsp);
      for (int i = 31; i >= 0; i--) begin
         mosi_o = ins[i];
         #(half);
         sck_o  = 1'b1;
         rsp[i] = miso_i;
         #(half);
         sck_o  = 1'b0;
      end
      mosi_o = ~mosi_o; // released data line must not look held
   endtask
endmodule

/* tb/sice_engine_tb.sv */
// self-checking bench of the isp command engine
`timescale 1ns/10ps
module sice_engine_tb;
   import sice_pkg::*;
   localparam logic [7:0] WSUB [4] =
      '{SICE_SUB_FLO, SICE_SUB_FHI, SICE_SUB_FEXT, SICE_SUB_LOCK};
   localparam logic [15:0] RSEL [4] = '{16'h5000, 16'h5808, 16'h5008, 16'h5800};
   logic        clock_i, rst_i, reset_pin_i, sck, mosi, miso, mode, pend;
   logic [7:0]  ext, a, d, hb, pg, e, fl;
   logic [31:0] lfsr_q, rsp;
   logic [15:0] fl_exp [int];
   int          err_total, n_compared, half_ns;
   // core clock
   initial clock_i = 1'b0;
   always #4 clock_i = ~clock_i;
   sice_engine #(.FLASH_WAIT_CYC(100), .EEPROM_WAIT_CYC(100),
      .ERASE_WAIT_CYC(100), .FUSE_WAIT_CYC(100)) dut_u (
      .clock_i(clock_i), .rst_i(rst_i), .reset_pin_i(reset_pin_i),
      .sck_i(sck), .mosi_i(mosi), .miso_o(miso), .prog_mode_o(mode),
      .operation_pending_flag_o(pend), .ext_addr_o(ext));
   sice_prog_model prog_u (.sck_o(sck), .mosi_o(mosi), .miso_i(miso));
   // next pseudo-random byte
   function automatic logic [7:0] rnd8();
      lfsr_q = {lfsr_q[30:0], lfsr_q[31] ^ lfsr_q[21] ^ lfsr_q[1] ^ lfsr_q[0]};
      return lfsr_q[7:0];
   endfunction
   task automatic cmp8(input logic [7:0] got, exp, input string what);
      n_compared++;
      if (got !== exp) begin
         err_total++;
         $display("Error %0t: %s got %h expected %h", $time, what, got, exp);
      end
   endtask
   task automatic send(input logic [31:0] ins);
      @(negedge clock_i);
      #(1 + rnd8() % 3); // link edges drift against the core clock
      prog_u.xfer(ins, half_ns, rsp);
   endtask
   task automatic rd(input logic [31:0] ins, input logic [7:0] exp);
      send(ins);
      cmp8(rsp[7:0], exp, "read");
   endtask
   task automatic wait_idle();
      int n;
      n = 0;
      do begin
         send({SICE_OP_POLL, 24'h0});
         n++;
      end while (rsp[0] !== 1'b0 && n < 40);
      cmp8({7'h00, rsp[0]}, 8'h00, "poll");
   endtask
   task automatic print_verdict();
      $display("compared %0d mismatches %0d", n_compared, err_total);
      if (err_total == 0 && n_compared > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask
   // watchdog
   initial begin
      #750000;
      err_total++;
      $display("Error %0t: watchdog expired", $time);
      print_verdict();
   end
   // main sequence
   initial begin
      err_total = 0;
      n_compared = 0;
      half_ns = 80;
      lfsr_q = 32'h6F9D;
      rst_i = 1'b1;
      reset_pin_i = 1'b1; // power-up pulse clears the link shifter
      repeat (12) @(negedge clock_i);
      rst_i = 1'b0;
      reset_pin_i = 1'b0;
      repeat (4) @(negedge clock_i);
      send({SICE_OP_AC, SICE_SUB_FLO, 16'h0000});
      rd({SICE_OP_FRD0, 24'h0}, SICE_FUSE_RST);
      send({SICE_OP_AC, SICE_SUB_EN, 16'h0000});
      cmp8(rsp[15:8], SICE_SUB_EN, "echo");
      cmp8({7'h00, mode}, 8'h01, "mode");
      send({SICE_OP_AC, SICE_SUB_ERASE, 16'h0000});
      cmp8({7'h00, pend}, 8'h01, "busy");
      wait_idle();
      for (int i = 0; i < 4; i++) begin
         a = rnd8() & 8'h1F;
         d = rnd8();
         rd({SICE_OP_RDLO, a, d, 8'h00}, SICE_ERASED);
         rd({SICE_OP_RDHI, a, d, 8'h00}, SICE_ERASED);
         rd({SICE_OP_EERD, 7'h00, a[0], d, 8'h00}, SICE_ERASED);
      end
      $display("test erase done");
      hb = rnd8() & 8'h1F;
      pg = rnd8() & 8'hC0;
      for (int i = 0; i < 3; i++) begin
         e = (i == 0) ? 8'h00 : (i == 1) ? 8'h3F : rnd8() & 8'h3F;
         a = rnd8();
         d = rnd8();
         send({SICE_OP_LDLO, 8'h00, pg | e, a});
         send({SICE_OP_LDHI, 8'h00, pg | e, d});
         fl_exp[e] = {d, a};
      end
      send({SICE_OP_WRPG, hb, pg | (rnd8() & 8'h3F), 8'h00});
      wait_idle();
      foreach (fl_exp[k]) begin
         rd({SICE_OP_RDLO, hb, pg | k[7:0], 8'h00}, fl_exp[k][7:0]);
         rd({SICE_OP_RDHI, hb, pg | k[7:0], 8'h00}, fl_exp[k][15:8]);
      end
      $display("test flash page done");
      e = rnd8();
      repeat (2) begin
         d = rnd8() & 8'h7F;
         send({SICE_OP_EEWR, 7'h00, e[6], e[5:0], 2'b01, d});
         wait_idle();
         rd({SICE_OP_EERD, 7'h00, e[6], e[5:0], 2'b01, 8'h00}, d);
      end
      a = rnd8();
      hb = rnd8();
      send({SICE_OP_EELD, 16'h0000, a});
      send({SICE_OP_EELD, 16'h0002, hb});
      send({SICE_OP_EEPG, 7'h00, e[6], e[5:0], 2'b00, 8'h00});
      wait_idle();
      for (int s = 0; s < 4; s++)
         rd({SICE_OP_EERD, 7'h00, e[6], e[5:0], s[1:0], 8'h00},
            s == 0 ? a : s == 1 ? d : s == 2 ? hb : SICE_ERASED);
      d = rnd8();
      send({SICE_OP_EELD, 16'h0003, d});
      rd({SICE_OP_EERD, 7'h00, e[6], e[5:0], 2'b11, 8'h00},
         SICE_ERASED);
      send({SICE_OP_EEPG, 7'h00, e[6], e[5:0], 2'b00, 8'h00});
      wait_idle();
      rd({SICE_OP_EERD, 7'h00, e[6], e[5:0], 2'b11, 8'h00}, d);
      rd({SICE_OP_EERD, 7'h00, e[6], e[5:0], 2'b00, 8'h00}, a);
      $display("test eeprom done");
      for (int i = 0; i < 4; i++) begin
         d = rnd8();
         if (i == 0)
            fl = d;
         send({SICE_OP_AC, WSUB[i], 8'h00, d});
         wait_idle();
         rd({RSEL[i], 16'h0000}, d);
      end
      d = rnd8();
      send({SICE_OP_EXT, 8'h00, d, 8'h00});
      cmp8(ext, d, "ext addr");
      $display("test fuse and ext done");
      @(negedge clock_i);
      reset_pin_i = 1'b1;
      repeat (6) @(negedge clock_i);
      cmp8({7'h00, mode}, 8'h00, "mode off");
      reset_pin_i = 1'b0;
      repeat (4) @(negedge clock_i);
      send({SICE_OP_AC, SICE_SUB_FLO, 8'h00, ~fl});
      rd({SICE_OP_FRD0, 24'h0}, fl);
      send({SICE_OP_AC, SICE_SUB_EN, 16'h0000});
      cmp8(rsp[15:8], SICE_SUB_EN, "echo");
      cmp8({7'h00, mode}, 8'h01, "mode again");
      $display("test reset pin done");
      print_verdict();
   end
endmodule
